// *** ofs_dly_filt.sv ***
/*
  Delay filter: the output takes a new input level only after it has stood for N clocks.
  Assumes the input is synchronous to clk.
*/
module ofs_dly_filt #(
  parameter int unsigned N = ofs_pkg::TRIP_DELAY_CYC
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_b,
  // Level in and filtered level out.
  input  wire logic raw,
  output logic      filt
);

  ofs_pkg::ofs_filt_t st_q;
  ofs_pkg::ofs_filt_t st_d;

  always_comb begin
    st_d = st_q;
    if (raw == st_q.out) begin
      st_d.cnt = '0;
    end else if (st_q.cnt == ofs_pkg::FILT_CNT_W'(N - 1)) begin
      st_d.out = raw;
      st_d.cnt = '0;
    end else begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign filt = st_q.out;

  AST_FILT_DELAY: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(st_q.out) |-> $past(st_q.cnt) == ofs_pkg::FILT_CNT_W'(N - 1) && $past(raw) == st_q.out)
    else $error("Filtered level changed before the delay ran out.");

endmodule

// *** ofs_pkg.sv ***
/*
  Constants, types and register map of the output fault supervisor.
  Assumes one 25 MHz clock, an APB master and measurements already digitised in mV and degC.
*/
// How it works
// - Undervoltage trips below a share of the setpoint, 75 percent by default, 80 or 85 by setting.
// - Undervoltage, overtemperature and tracking faults turn the output off about 6 us after crossing.
// - At or above 130 degC the output shuts down and may restart only once below 120 degC.
// - Tracking, when enabled, is checked only during the ramp up and trips beyond 250 mV either way.
// - An overtemperature warning at 120 degC with 3 degC hysteresis is a status flag only.
// - The warning flag follows its crossing after about 6 us.
// - The power-good pin is high inside a window from a programmable low limit to 110 percent.
// - The power-good pin follows a window crossing after about 6 us.
// - The overvoltage threshold is never below 1.0 V whatever the percentage.
// - Overvoltage trips above 130 percent of the setpoint by default, set in 10 percent steps.
package ofs_pkg;

  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned TRIP_DELAY_NS  = 6000;
  localparam int unsigned TRIP_DELAY_CYC = (TRIP_DELAY_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned RETRY_MS       = 130;
  localparam int unsigned RETRY_CYC      = RETRY_MS * (CLK_HZ / 1000);
  localparam int unsigned RETRY_W        = 22;
  localparam int unsigned FILT_CNT_W     = 8;

  localparam int unsigned PCT_SCALE      = 100;
  localparam int unsigned UV_BASE_PCT    = 75;
  localparam int unsigned UV_STEP_PCT    = 5;
  localparam int unsigned UV_MAX_PCT     = 85;
  localparam int unsigned OV_BASE_PCT    = 130;
  localparam int unsigned OV_STEP_PCT    = 10;
  localparam int unsigned OV_MIN_PCT     = 110;
  localparam int unsigned OV_FLOOR_MV    = 1000;
  localparam int unsigned PG_HI_PCT      = 110;
  localparam int unsigned PG_LO_MIN_PCT  = 70;
  localparam int unsigned PG_LO_STEP_PCT = 5;
  localparam int          OT_TRIP_C      = 130;
  localparam int          OT_RESTART_C   = 120;
  localparam int          OTW_SET_C      = 120;
  localparam int          OTW_HYST_C     = 3;
  localparam int          TRK_LIMIT_MV   = 250;

  localparam int unsigned ADDR_W         = 8;
  localparam logic [7:0]  OFF_CTRL       = 8'h00;
  localparam logic [7:0]  OFF_STATUS     = 8'h04;
  localparam logic [7:0]  OFF_MASK       = 8'h08;
  localparam logic [7:0]  OFF_LIVE       = 8'h0c;
  localparam logic [7:0]  OFF_CMD        = 8'h10;
  localparam int unsigned CMD_RESTART    = 0;

  localparam int unsigned NEV            = 6;
  localparam int unsigned NTRIP          = 4;
  localparam int unsigned EV_UV          = 0;
  localparam int unsigned EV_OV          = 1;
  localparam int unsigned EV_OT          = 2;
  localparam int unsigned EV_TRK         = 3;
  localparam int unsigned EV_OTW         = 4;
  localparam int unsigned EV_PG          = 5;
  localparam int unsigned LIVE_CAUSE_LSB = 6;
  localparam int unsigned LIVE_FSM_LSB   = 10;

  typedef enum logic [2:0] {
    FS_ON    = 3'b001,
    FS_RETRY = 3'b010,
    FS_LATCH = 3'b100
  } ofs_fsm_t;

  // Control register, bit 11 down to bit 0.
  typedef struct packed {
    logic [NTRIP-1:0] latch;
    logic             trk_en;
    logic [2:0]       pg_sel;
    logic [1:0]       ov_sel;
    logic [1:0]       uv_sel;
  } ofs_ctrl_t;

  localparam ofs_ctrl_t CTRL_RST = '{latch: 4'h0, trk_en: 1'b0, pg_sel: 3'h4,
                                     ov_sel: 2'h0, uv_sel: 2'h0};

  typedef struct packed {
    logic                  out;
    logic [FILT_CNT_W-1:0] cnt;
  } ofs_filt_t;

  typedef struct packed {
    ofs_fsm_t         fsm;
    logic [RETRY_W-1:0] retry_cnt;
    logic [NTRIP-1:0] cause;
    ofs_ctrl_t        ctrl;
    logic [NEV-1:0]   status;
    logic [NEV-1:0]   mask;
    logic [NEV-1:0]   fprev;
    logic             ack;
    logic             err;
    logic [31:0]      rdata;
  } ofs_state_t;

endpackage

// *** ofs_stage_model.sv ***
/*
  Power stage model: drives the measured output from a level the bench commands.
  Assumes the supervisor's out_enable gates the stage.
*/
module ofs_stage_model (
  // Gate and commanded level.
  input  wire logic        out_enable,
  input  wire logic [15:0] level_mv,
  // Measured output.
  output logic [15:0]      vout_mv
);
  timeunit 1ns;
  timeprecision 1ns;
  // A stage that is turned off discharges its output to zero.
  assign vout_mv = out_enable ? level_mv : 16'h0000;
endmodule

// *** ofs_supervisor.sv ***
/*
  Output fault supervisor: trips, retry or latch-off, warning, power-good pin and APB registers.
  Assumes APB master on clk, measured output, setpoint and ramp target in mV, temperature in degC.
*/
// Local design decisions: the address map and the APB slave port.
module ofs_supervisor #(
  parameter int unsigned RETRY_CYC = ofs_pkg::RETRY_CYC,
  parameter int unsigned DELAY_CYC = ofs_pkg::TRIP_DELAY_CYC
) (
  // Clock and reset.
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  // APB slave.
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ofs_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic                             pready,
  output logic [31:0]                      prdata,
  output logic                             pslverr,
  // Measurements.
  input  wire logic [15:0]                 vout_mv,
  input  wire logic [15:0]                 vset_mv,
  input  wire logic [15:0]                 ramp_target_mv,
  input  wire logic                        ramp_active,
  input  wire logic signed [9:0]           temp_c,
  // Power stage and system.
  output logic                             out_enable,
  output logic                             output_in_window_flag,
  output logic                             irq
);

  ofs_pkg::ofs_state_t st_q;
  ofs_pkg::ofs_state_t st_d;

  logic [ofs_pkg::NEV-1:0]   raw;
  logic [ofs_pkg::NEV-1:0]   filt;
  logic [ofs_pkg::NTRIP-1:0] trip;
  logic [7:0]                uv_pct;
  logic [7:0]                ov_pct;
  logic [7:0]                pg_pct;
  logic [23:0]               vo100;
  logic [23:0]               uv_thr;
  logic [23:0]               ov_thr;
  logic [23:0]               ov_pct_thr;
  logic [23:0]               pg_lo_thr;
  logic [23:0]               pg_hi_thr;
  logic signed [16:0]        trk_dev;
  logic                      fs_on;
  logic                      acc;
  logic                      wr;
  logic                      restart;
  logic [ofs_pkg::NEV-1:0]   ev;
  logic [ofs_pkg::NEV-1:0]   rd_clr;

  assign fs_on = (st_q.fsm == ofs_pkg::FS_ON);

  // Threshold percentages from the control register.
  always_comb begin
    if (st_q.ctrl.uv_sel > 2'h2) begin
      uv_pct = 8'(ofs_pkg::UV_MAX_PCT);
    end else begin
      uv_pct = 8'(ofs_pkg::UV_BASE_PCT + ofs_pkg::UV_STEP_PCT * st_q.ctrl.uv_sel);
    end
    if (st_q.ctrl.ov_sel > 2'h2) begin
      ov_pct = 8'(ofs_pkg::OV_MIN_PCT);
    end else begin
      ov_pct = 8'(ofs_pkg::OV_BASE_PCT - ofs_pkg::OV_STEP_PCT * st_q.ctrl.ov_sel);
    end
    pg_pct = 8'(ofs_pkg::PG_LO_MIN_PCT + ofs_pkg::PG_LO_STEP_PCT * st_q.ctrl.pg_sel);
  end

  // Thresholds compared in units of mV times one hundred.
  always_comb begin
    vo100      = 24'(vout_mv) * 24'(ofs_pkg::PCT_SCALE);
    uv_thr     = 24'(vset_mv) * 24'(uv_pct);
    ov_pct_thr = 24'(vset_mv) * 24'(ov_pct);
    pg_lo_thr  = 24'(vset_mv) * 24'(pg_pct);
    pg_hi_thr  = 24'(vset_mv) * 24'(ofs_pkg::PG_HI_PCT);
    if (ov_pct_thr < 24'(ofs_pkg::OV_FLOOR_MV * ofs_pkg::PCT_SCALE)) begin
      ov_thr = 24'(ofs_pkg::OV_FLOOR_MV * ofs_pkg::PCT_SCALE);
    end else begin
      ov_thr = ov_pct_thr;
    end
    trk_dev = $signed({1'b0, vout_mv}) - $signed({1'b0, ramp_target_mv});
  end

  // Raw fault and window levels before the delay filters.
  always_comb begin
    raw                  = '0;
    raw[ofs_pkg::EV_UV]  = fs_on && (vo100 < uv_thr);
    raw[ofs_pkg::EV_OV]  = vo100 > ov_thr;
    if (filt[ofs_pkg::EV_OT]) begin
      raw[ofs_pkg::EV_OT] = temp_c >= ofs_pkg::OT_RESTART_C;
    end else begin
      raw[ofs_pkg::EV_OT] = temp_c >= ofs_pkg::OT_TRIP_C;
    end
    raw[ofs_pkg::EV_TRK] = st_q.ctrl.trk_en && ramp_active &&
                           (trk_dev > ofs_pkg::TRK_LIMIT_MV || trk_dev < -ofs_pkg::TRK_LIMIT_MV);
    if (filt[ofs_pkg::EV_OTW]) begin
      raw[ofs_pkg::EV_OTW] = temp_c >= ofs_pkg::OTW_SET_C - ofs_pkg::OTW_HYST_C;
    end else begin
      raw[ofs_pkg::EV_OTW] = temp_c >= ofs_pkg::OTW_SET_C;
    end
    raw[ofs_pkg::EV_PG]  = (vo100 >= pg_lo_thr) && (vo100 <= pg_hi_thr);
  end

  // One delay filter per monitored level.
  for (genvar i = 0; i < ofs_pkg::NEV; i++) begin : g_filt
    ofs_dly_filt #(
      .N (DELAY_CYC)
    ) u_filt (
      .clk   (clk),
      .rst_b (rst_b),
      .raw   (raw[i]),
      .filt  (filt[i])
    );
  end

  assign trip    = filt[ofs_pkg::NTRIP-1:0];
  assign acc     = psel && penable && st_q.ack;
  assign wr      = acc && pwrite;
  assign restart = wr && (paddr == ofs_pkg::OFF_CMD) && pwdata[ofs_pkg::CMD_RESTART];
  assign rd_clr  = (acc && !pwrite && paddr == ofs_pkg::OFF_STATUS) ?
                   st_q.rdata[ofs_pkg::NEV-1:0] : '0;

  always_comb begin
    ev                     = '0;
    ev[ofs_pkg::NTRIP-1:0] = fs_on ? trip : '0;
    ev[ofs_pkg::EV_OTW]    = filt[ofs_pkg::EV_OTW] && !st_q.fprev[ofs_pkg::EV_OTW];
    ev[ofs_pkg::EV_PG]     = filt[ofs_pkg::EV_PG] != st_q.fprev[ofs_pkg::EV_PG];
  end

  // Next state.
  always_comb begin
    st_d       = st_q;
    st_d.fprev = filt;
    st_d.status = (st_q.status & ~rd_clr) | ev;
    unique case (st_q.fsm)
      ofs_pkg::FS_ON: begin
        if (|trip) begin
          st_d.cause     = trip;
          st_d.retry_cnt = ofs_pkg::RETRY_W'(RETRY_CYC - 1);
          if (|(trip & st_q.ctrl.latch)) begin
            st_d.fsm = ofs_pkg::FS_LATCH;
          end else begin
            st_d.fsm = ofs_pkg::FS_RETRY;
          end
        end
      end
      ofs_pkg::FS_RETRY: begin
        if (st_q.retry_cnt != '0) begin
          st_d.retry_cnt = st_q.retry_cnt - 1'b1;
        end else if (!filt[ofs_pkg::EV_OT]) begin
          st_d.fsm = ofs_pkg::FS_ON;
        end else begin
          st_d.retry_cnt = ofs_pkg::RETRY_W'(RETRY_CYC - 1);
        end
        if (restart && !filt[ofs_pkg::EV_OT]) begin
          st_d.fsm = ofs_pkg::FS_ON;
        end
      end
      ofs_pkg::FS_LATCH: begin
        if (restart && !filt[ofs_pkg::EV_OT]) begin
          st_d.fsm = ofs_pkg::FS_ON;
        end
      end
      default: begin
        st_d.fsm = ofs_pkg::FS_LATCH;
      end
    endcase
    if (wr && paddr == ofs_pkg::OFF_CTRL) begin
      st_d.ctrl = ofs_pkg::ofs_ctrl_t'(pwdata[$bits(ofs_pkg::ofs_ctrl_t)-1:0]);
    end
    if (wr && paddr == ofs_pkg::OFF_MASK) begin
      st_d.mask = pwdata[ofs_pkg::NEV-1:0];
    end
    // Setup phase captures read data so the access phase answers from flops.
    st_d.ack = psel && !penable;
    if (psel && !penable) begin
      st_d.err   = 1'b0;
      st_d.rdata = '0;
      unique case (paddr)
        ofs_pkg::OFF_CTRL: begin
          st_d.rdata[$bits(ofs_pkg::ofs_ctrl_t)-1:0] = st_q.ctrl;
        end
        ofs_pkg::OFF_STATUS: begin
          st_d.rdata[ofs_pkg::NEV-1:0] = st_q.status;
        end
        ofs_pkg::OFF_MASK: begin
          st_d.rdata[ofs_pkg::NEV-1:0] = st_q.mask;
        end
        ofs_pkg::OFF_LIVE: begin
          st_d.rdata[ofs_pkg::NEV-1:0] = filt;
          st_d.rdata[ofs_pkg::LIVE_CAUSE_LSB +: ofs_pkg::NTRIP] = st_q.cause;
          st_d.rdata[ofs_pkg::LIVE_FSM_LSB +: 3] = st_q.fsm;
        end
        ofs_pkg::OFF_CMD: begin
          st_d.rdata = '0;
        end
        default: begin
          st_d.err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '{fsm: ofs_pkg::FS_ON, ctrl: ofs_pkg::CTRL_RST, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign pready                = acc;
  assign pslverr               = acc && st_q.err;
  assign prdata                = st_q.rdata;
  assign out_enable            = st_q.fsm[0];
  assign output_in_window_flag = filt[ofs_pkg::EV_PG];
  assign irq                   = |(st_q.status & st_q.mask);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_UV_TURNOFF: assert property (
    fs_on && filt[ofs_pkg::EV_UV] |=> !out_enable ##1 !out_enable)
    else $error("Undervoltage did not turn the output off.");

  AST_TRIP_ONE_CYCLE: assert property (
    $rose(filt[ofs_pkg::EV_TRK]) && fs_on |=> !out_enable && st_q.cause[ofs_pkg::EV_TRK])
    else $error("Tracking trip did not switch the output off on the next edge.");

  AST_OT_RESTART: assert property (
    $rose(out_enable) |-> !$past(filt[ofs_pkg::EV_OT]))
    else $error("Output restarted while overtemperature was still held.");

  AST_TRK_RAMP: assert property (
    $rose(filt[ofs_pkg::EV_TRK]) |-> $past(ramp_active) && $past(st_q.ctrl.trk_en))
    else $error("Tracking fault flagged outside the ramp up.");

  AST_OTW_NO_OFF: assert property (
    fs_on && !(|trip) |=> out_enable)
    else $error("Output turned off with no trip present.");

  AST_OTW_STATUS: assert property (
    $rose(filt[ofs_pkg::EV_OTW]) |=> st_q.status[ofs_pkg::EV_OTW])
    else $error("Warning did not set its status bit.");

  AST_OV_FLOOR: assert property (
    vo100 <= 24'(ofs_pkg::OV_FLOOR_MV * ofs_pkg::PCT_SCALE) |-> !raw[ofs_pkg::EV_OV])
    else $error("Overvoltage seen below the 1 V floor.");

  AST_RETRY_WAIT: assert property (
    st_q.fsm == ofs_pkg::FS_RETRY && st_q.retry_cnt != '0 && !restart
    |=> st_q.fsm == ofs_pkg::FS_RETRY && st_q.retry_cnt == $past(st_q.retry_cnt) - 1'b1)
    else $error("Retry wait did not count down.");

  AST_LATCH_HOLD: assert property (
    st_q.fsm == ofs_pkg::FS_LATCH && !restart |=> st_q.fsm == ofs_pkg::FS_LATCH)
    else $error("Latched fault released without a restart.");

  AST_APB_ONE_WAIT: assert property (
    psel && !penable ##1 psel && penable |-> pready)
    else $error("APB access phase did not complete in one cycle.");

  CVR_RETRY: cover property (st_q.fsm == ofs_pkg::FS_RETRY ##1 fs_on);
  CVR_LATCH: cover property (st_q.fsm == ofs_pkg::FS_LATCH ##1 fs_on);
  CVR_OTW: cover property ($rose(filt[ofs_pkg::EV_OTW]));
  CVR_PG: cover property ($rose(output_in_window_flag));

endmodule

// *** tb_top.sv ***
/*
  Self-checking bench of the output fault supervisor.
  Assumes the supervisor with short delay and retry counts and the stage model.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DLY = 8;
  localparam int RET = 300;
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0000_0000;
  logic [31:0]       prdata;
  logic              pready, pslverr, out_en, pg, irq, last_err;
  logic              ramp_act = 1'b0;
  logic [15:0]       vout;
  logic [15:0]       vset = 16'h03e8;
  logic [15:0]       lvl = 16'h03e8;
  logic [15:0]       tgt = 16'h03e8;
  logic signed [9:0] temp = 10'h019;
  int                num_errors = 0;
  int                total_checks = 0;
  int                cyc = 0;

  always #20 clk = ~clk;

  ofs_supervisor #(.RETRY_CYC(RET), .DELAY_CYC(DLY)) i_dut (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .vout_mv(vout), .vset_mv(vset), .ramp_target_mv(tgt), .ramp_active(ramp_act),
    .temp_c(temp), .out_enable(out_en), .output_in_window_flag(pg), .irq(irq));

  ofs_stage_model i_stage (.out_enable(out_en), .level_mv(lvl), .vout_mv(vout));

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk_b(n == 1, 1'b1, "bus answer");
  endtask

  task automatic w(input logic [7:0] a, input int d);
    logic [31:0] x;
    apb(1'b1, a, 32'(d), x);
  endtask

  task automatic r(input logic [7:0] a, output logic [31:0] d);
    apb(1'b0, a, 32'h0000_0000, d);
  endtask

  task automatic setv(input int mv);
    @(posedge clk);
    lvl <= 16'(mv);
  endtask

  task automatic sett(input int t);
    @(posedge clk);
    temp <= 10'(t);
  endtask

  task automatic edges(input bit on_pg, input logic want, input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((on_pg ? pg : out_en) !== want && n < lim);
    chk_b(on_pg ? pg : out_en, want, "level reached");
  endtask

  task automatic t_reset;
    logic [31:0] d;
    chk_b(out_en, 1'b1, "enable after reset");
    chk_b(irq, 1'b0, "irq after reset");
    r(ofs_pkg::OFF_CTRL, d);
    chk_w(d, 32'(ofs_pkg::CTRL_RST), "ctrl reset");
    r(ofs_pkg::OFF_MASK, d);
    chk_w(d, 32'h0000_0000, "mask reset");
    r(8'h14, d);
    chk_b(last_err, 1'b1, "unmapped error");
    chk_w(d, 32'h0000_0000, "unmapped data");
    $display("test reset done");
  endtask

  task automatic t_thr;
    int c[9] = '{'h040, 'h041, 'h042, 'h043, 'h040, 'h044, 'h048, 'h04c, 'h040};
    int p[9] = '{75, 80, 85, 85, 130, 120, 110, 110, 130};
    int vs[9] = '{1000, 1000, 1000, 1000, 1000, 1000, 1000, 1000, 500};
    int ok, n, m;
    bit ov;
    logic [31:0] d;
    for (int i = 0; i < 9; i++) begin
      ov = (i > 3);
      ok = vs[i] * p[i] / 100;
      if (ov && ok < 1000) begin
        ok = 1000;
      end
      @(posedge clk);
      vset <= 16'(vs[i]);
      lvl <= 16'(vs[i]);
      w(ofs_pkg::OFF_CTRL, c[i]);
      setv(ok);
      repeat (2 * DLY) @(posedge clk);
      chk_b(out_en, 1'b1, "no trip at limit");
      setv(ov ? ok + 1 : ok - 1);
      edges(0, 1'b0, DLY + 4, n);
      chk_w(32'(n), 32'(DLY + 1), "trip delay");
      setv(vs[i]);
      edges(0, 1'b1, RET + 20, m);
      chk_b(m + 1 >= RET - 2 && m + 1 <= RET + 2, 1'b1, "retry period");
      r(ofs_pkg::OFF_STATUS, d);
      chk_b(d[ov], 1'b1, "trip status");
      repeat (2 * DLY) @(posedge clk);
    end
    @(posedge clk);
    vset <= 16'h03e8;
    lvl <= 16'h03e8;
    w(ofs_pkg::OFF_CTRL, 'h040);
    $display("test thresholds done");
  endtask

  task automatic t_pg;
    int sel[2] = '{4, 2};
    int lo, n;
    logic [31:0] d;
    w(ofs_pkg::OFF_MASK, 'h20);
    for (int i = 0; i < 2; i++) begin
      lo = 1000 * (70 + 5 * sel[i]) / 100;
      w(ofs_pkg::OFF_CTRL, sel[i] << 4);
      setv(1000);
      repeat (2 * DLY) @(posedge clk);
      chk_b(pg, 1'b1, "window high");
      setv(1101);
      edges(1, 1'b0, DLY + 4, n);
      chk_w(32'(n), 32'(DLY), "above window");
      setv(1100);
      edges(1, 1'b1, DLY + 4, n);
      chk_w(32'(n), 32'(DLY), "upper edge");
      setv(lo - 1);
      edges(1, 1'b0, DLY + 4, n);
      chk_w(32'(n), 32'(DLY), "below window");
      setv(lo);
      edges(1, 1'b1, DLY + 4, n);
      chk_w(32'(n), 32'(DLY), "lower edge");
    end
    chk_b(irq, 1'b1, "irq raised");
    r(ofs_pkg::OFF_STATUS, d);
    @(posedge clk);
    #1;
    chk_b(irq, 1'b0, "irq cleared");
    w(ofs_pkg::OFF_MASK, 'h00);
    w(ofs_pkg::OFF_CTRL, 'h040);
    $display("test power good done");
  endtask

  task automatic t_trk;
    int tg[2] = '{1000, 1500};
    int ok, n;
    logic [31:0] d;
    for (int k = 0; k < 2; k++) begin
      ok = k ? tg[k] - 250 : tg[k] + 250;
      @(posedge clk);
      vset <= 16'h0640;
      lvl <= 16'h0578;
      tgt <= 16'(tg[k]);
      ramp_act <= 1'b0;
      w(ofs_pkg::OFF_CTRL, 'h0c0);
      repeat (2 * DLY) @(posedge clk);
      chk_b(out_en, 1'b1, "not ramping");
      @(posedge clk);
      ramp_act <= 1'b1;
      lvl <= 16'(ok);
      repeat (2 * DLY) @(posedge clk);
      chk_b(out_en, 1'b1, "track at limit");
      setv(k ? ok - 1 : ok + 1);
      edges(0, 1'b0, DLY + 4, n);
      chk_w(32'(n), 32'(DLY + 1), "track delay");
      r(ofs_pkg::OFF_LIVE, d);
      chk_w(32'(d[9:6]), 32'h8, "track cause");
      @(posedge clk);
      ramp_act <= 1'b0;
      lvl <= 16'h0640;
      edges(0, 1'b1, RET + 20, n);
      repeat (2 * DLY) @(posedge clk);
    end
    @(posedge clk);
    vset <= 16'h03e8;
    lvl <= 16'h03e8;
    w(ofs_pkg::OFF_CTRL, 'h040);
    $display("test tracking done");
  endtask

  task automatic t_latch;
    int n;
    logic [31:0] d;
    w(ofs_pkg::OFF_CTRL, 'h140);
    setv(749);
    edges(0, 1'b0, DLY + 4, n);
    setv(1000);
    repeat (RET + 20) @(posedge clk);
    chk_b(out_en, 1'b0, "latched off");
    r(ofs_pkg::OFF_LIVE, d);
    chk_w(32'(d[12:10]), 32'h4, "latched state");
    w(ofs_pkg::OFF_CMD, 1);
    edges(0, 1'b1, 4, n);
    chk_b(out_en, 1'b1, "restart");
    w(ofs_pkg::OFF_CTRL, 'h040);
    repeat (2 * DLY) @(posedge clk);
    $display("test latch done");
  endtask

  task automatic t_ot;
    int n;
    logic [31:0] d;
    sett(129);
    repeat (2 * DLY) @(posedge clk);
    r(ofs_pkg::OFF_LIVE, d);
    chk_b(d[4], 1'b1, "warning set");
    chk_b(out_en, 1'b1, "warning keeps on");
    sett(118);
    repeat (2 * DLY) @(posedge clk);
    r(ofs_pkg::OFF_LIVE, d);
    chk_b(d[4], 1'b1, "warning hysteresis");
    sett(116);
    repeat (2 * DLY) @(posedge clk);
    r(ofs_pkg::OFF_LIVE, d);
    chk_b(d[4], 1'b0, "warning clear");
    sett(130);
    edges(0, 1'b0, DLY + 4, n);
    chk_w(32'(n), 32'(DLY + 1), "over temp delay");
    sett(121);
    repeat (RET + 20) @(posedge clk);
    chk_b(out_en, 1'b0, "no restart when hot");
    sett(119);
    edges(0, 1'b1, RET + DLY + 20, n);
    chk_b(out_en, 1'b1, "restart when cool");
    sett(25);
    $display("test over temperature done");
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset;
    t_thr;
    t_pg;
    t_trk;
    t_latch;
    t_ot;
    wrap_up;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      $display("mismatch at %0t: run too long", $time);
      wrap_up;
    end
  end
endmodule
